/* src/dual_timer.sv */
// Dual timer/counter with APB registers and external irq flags
`timescale 1ns/1ps
module dual_timer (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        ext_irq0_pin,
  input  wire logic        ext_irq1_pin,
  input  wire logic        chan0_count_pin,
  input  wire logic        chan1_count_pin,
  output logic             irq
);
  logic [7:0] timer_control_reg_q;
  logic [7:0] timer_mode_reg_q;
  logic [7:0] chan0_low_byte_q;
  logic [7:0] chan0_high_byte_q;
  logic [7:0] chan1_low_byte_q;
  logic [7:0] chan1_high_byte_q;
  logic [3:0] irq_stat_q;
  logic [3:0] irq_en_q;
  logic       smp0_q;
  logic       smp0_prev_q;
  logic       smp1_q;
  logic       smp1_prev_q;
  logic       ext0_prev_q;
  logic       ext1_prev_q;
  logic       tick;

  tick_div #(
    .DIV (tmr_pkg::OSC_DIV)
  ) u_div (
    .pclk    (pclk),
    .presetn (presetn),
    .tick    (tick)
  );

  // APB decode; zero wait states
  wire wr_en = psel && penable && pwrite;
  wire wr_ctrl  = wr_en && (paddr == tmr_pkg::OFF_CTRL);
  wire wr_mode  = wr_en && (paddr == tmr_pkg::OFF_MODE);
  wire wr_l0    = wr_en && (paddr == tmr_pkg::OFF_CH0_LOW);
  wire wr_l1    = wr_en && (paddr == tmr_pkg::OFF_CH1_LOW);
  wire wr_h0    = wr_en && (paddr == tmr_pkg::OFF_CH0_HIGH);
  wire wr_h1    = wr_en && (paddr == tmr_pkg::OFF_CH1_HIGH);
  wire wr_en_r  = wr_en && (paddr == tmr_pkg::OFF_IRQ_EN);
  wire wr_clr   = wr_en && (paddr == tmr_pkg::OFF_IRQ_CLR);
  wire wr_svc   = wr_en && (paddr == tmr_pkg::OFF_SERVICE);
  wire known = (paddr == tmr_pkg::OFF_CTRL) || (paddr == tmr_pkg::OFF_MODE)
            || (paddr == tmr_pkg::OFF_CH0_LOW) || (paddr == tmr_pkg::OFF_CH1_LOW)
            || (paddr == tmr_pkg::OFF_CH0_HIGH) || (paddr == tmr_pkg::OFF_CH1_HIGH)
            || (paddr == tmr_pkg::OFF_IRQ_STAT) || (paddr == tmr_pkg::OFF_IRQ_EN)
            || (paddr == tmr_pkg::OFF_IRQ_CLR) || (paddr == tmr_pkg::OFF_SERVICE);

  // Mode register fields, channel one in upper nibble
  wire [3:0] nib0 = timer_mode_reg_q[3:0];
  wire [3:0] nib1 = timer_mode_reg_q[7:4];
  wire [1:0] m0 = nib0[tmr_pkg::MODE_HI:tmr_pkg::MODE_LO];
  wire [1:0] m1 = nib1[tmr_pkg::MODE_HI:tmr_pkg::MODE_LO];
  wire run0 = timer_control_reg_q[tmr_pkg::CTRL_RUN0];
  wire run1 = timer_control_reg_q[tmr_pkg::CTRL_RUN1];

  // Counter input: falling edge seen across two tick samples
  wire fall0 = smp0_prev_q && !smp0_q;
  wire fall1 = smp1_prev_q && !smp1_q;
  wire ev0 = tick && (nib0[tmr_pkg::MODE_CT] ? fall0 : 1'b1);
  wire ev1 = tick && (nib1[tmr_pkg::MODE_CT] ? fall1 : 1'b1);

  // Gating by run bit, gate bit and irq pin
  wire en0 = run0 && (!nib0[tmr_pkg::MODE_GATE] || ext_irq0_pin);
  wire en1 = run1 && (!nib1[tmr_pkg::MODE_GATE] || ext_irq1_pin);
  wire inc0 = ev0 && en0;
  // Channel one halts in its own mode 3
  wire inc1 = ev1 && en1 && (m1 != tmr_pkg::MODE_SPLIT);
  wire split = (m0 == tmr_pkg::MODE_SPLIT);
  wire inc_h0_split = split && tick && run1;

  // Next-value and overflow per mode
  function automatic logic [16:0] step(input logic [1:0] m, input logic [7:0] lo,
                                       input logic [7:0] hi);
    logic [16:0] r;
    logic [8:0]  l9;
    logic [13:0] c13;
    r = {1'b0, hi, lo};
    l9 = {1'b0, lo} + 9'h001;
    c13 = {1'b0, hi, lo[4:0]} + 14'h0001;
    case (m)
      tmr_pkg::MODE_13BIT:
        r = {c13[13], c13[12:5], lo[7:5], c13[4:0]};
      tmr_pkg::MODE_16BIT:
        r = {1'b0, hi, lo} + 17'h00001;
      tmr_pkg::MODE_RELOAD,
      tmr_pkg::MODE_SPLIT:
        r = {l9[8], hi, (m == tmr_pkg::MODE_RELOAD && l9[8]) ? hi : l9[7:0]};
      default:
        r = {1'b0, hi, lo};
    endcase
    return r;
  endfunction : step

  wire [16:0] nx0 = step(m0, chan0_low_byte_q, chan0_high_byte_q);
  wire [16:0] nx1 = step(m1, chan1_low_byte_q, chan1_high_byte_q);
  wire [8:0]  h0s = {1'b0, chan0_high_byte_q} + 9'h001;
  wire ovf0 = inc0 && nx0[16];
  wire ovf1 = (inc1 && nx1[16] && !split) || (inc_h0_split && h0s[8]);

  // External irq detection by trigger type
  wire typ0 = timer_control_reg_q[tmr_pkg::CTRL_TYP0];
  wire typ1 = timer_control_reg_q[tmr_pkg::CTRL_TYP1];
  wire act0 = typ0 ? (ext0_prev_q && !ext_irq0_pin) : !ext_irq0_pin;
  wire act1 = typ1 ? (ext1_prev_q && !ext_irq1_pin) : !ext_irq1_pin;

  // Service acknowledge clears flags; a new event wins
  wire [3:0] svc = wr_svc ? pwdata[3:0] : 4'h0;
  wire [3:0] evts = {ovf1, ovf0, act1, act0};

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      smp0_q      <= 1'b1;
      smp0_prev_q <= 1'b1;
      smp1_q      <= 1'b1;
      smp1_prev_q <= 1'b1;
      ext0_prev_q <= 1'b1;
      ext1_prev_q <= 1'b1;
    end
    else
    begin
      ext0_prev_q <= ext_irq0_pin;
      ext1_prev_q <= ext_irq1_pin;
      if (tick)
      begin
        smp0_prev_q <= smp0_q;
        smp0_q      <= chan0_count_pin;
        smp1_prev_q <= smp1_q;
        smp1_q      <= chan1_count_pin;
      end
    end
  end

  // Control register: run and type bits written, flags set by hardware
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      timer_control_reg_q <= tmr_pkg::CTRL_RESET;
    else
    begin
      if (wr_ctrl)
      begin
        timer_control_reg_q[tmr_pkg::CTRL_RUN1] <= pwdata[tmr_pkg::CTRL_RUN1];
        timer_control_reg_q[tmr_pkg::CTRL_RUN0] <= pwdata[tmr_pkg::CTRL_RUN0];
        timer_control_reg_q[tmr_pkg::CTRL_TYP1] <= pwdata[tmr_pkg::CTRL_TYP1];
        timer_control_reg_q[tmr_pkg::CTRL_TYP0] <= pwdata[tmr_pkg::CTRL_TYP0];
      end
      timer_control_reg_q[tmr_pkg::CTRL_OVF1] <= ovf1 ||
        (timer_control_reg_q[tmr_pkg::CTRL_OVF1] && !svc[3]);
      timer_control_reg_q[tmr_pkg::CTRL_OVF0] <= ovf0 ||
        (timer_control_reg_q[tmr_pkg::CTRL_OVF0] && !svc[2]);
      timer_control_reg_q[tmr_pkg::CTRL_EXT1] <= act1 ||
        (timer_control_reg_q[tmr_pkg::CTRL_EXT1] && !svc[1]);
      timer_control_reg_q[tmr_pkg::CTRL_EXT0] <= act0 ||
        (timer_control_reg_q[tmr_pkg::CTRL_EXT0] && !svc[0]);
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      timer_mode_reg_q <= tmr_pkg::MODE_RESET;
    else if (wr_mode)
      timer_mode_reg_q <= pwdata[7:0];
  end

  // Count bytes; a bus write beats a same-cycle increment
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      chan0_low_byte_q <= 8'h00;
    else if (wr_l0)
      chan0_low_byte_q <= pwdata[7:0];
    else if (inc0)
      chan0_low_byte_q <= nx0[7:0];
  end

  // Split mode hands the high byte to channel one's run bit
  wire       hi0_step = split ? inc_h0_split : inc0;
  wire [7:0] hi0_next = split ? h0s[7:0] : nx0[15:8];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      chan0_high_byte_q <= 8'h00;
    else if (wr_h0)
      chan0_high_byte_q <= pwdata[7:0];
    else if (hi0_step)
      chan0_high_byte_q <= hi0_next;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      chan1_low_byte_q <= 8'h00;
    else if (wr_l1)
      chan1_low_byte_q <= pwdata[7:0];
    else if (inc1)
      chan1_low_byte_q <= nx1[7:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      chan1_high_byte_q <= 8'h00;
    else if (wr_h1)
      chan1_high_byte_q <= pwdata[7:0];
    else if (inc1)
      chan1_high_byte_q <= nx1[15:8];
  end

  // Sticky status: set wins over clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_stat_q <= 4'h0;
      irq_en_q   <= 4'h0;
    end
    else
    begin
      irq_stat_q <= evts | (irq_stat_q & ~(wr_clr ? pwdata[3:0] : 4'h0));
      if (wr_en_r)
        irq_en_q <= pwdata[3:0];
    end
  end

  assign irq = |(irq_stat_q & irq_en_q);

  wire [7:0] rd_byte =
      (paddr == tmr_pkg::OFF_CTRL)     ? timer_control_reg_q :
      (paddr == tmr_pkg::OFF_MODE)     ? timer_mode_reg_q :
      (paddr == tmr_pkg::OFF_CH0_LOW)  ? chan0_low_byte_q :
      (paddr == tmr_pkg::OFF_CH1_LOW)  ? chan1_low_byte_q :
      (paddr == tmr_pkg::OFF_CH0_HIGH) ? chan0_high_byte_q :
      (paddr == tmr_pkg::OFF_CH1_HIGH) ? chan1_high_byte_q :
      (paddr == tmr_pkg::OFF_IRQ_STAT) ? {4'h0, irq_stat_q} :
      (paddr == tmr_pkg::OFF_IRQ_EN)   ? {4'h0, irq_en_q} : 8'h00;

  assign prdata  = {24'h000000, rd_byte};
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !known;
endmodule : dual_timer

/* src/tmr_pkg.sv */
// Package of offsets, fields and timing constants for the dual timer block
// Functional notes
// - Mode 0 counts 13 bits, low five
// - Rollover to zero sets overflow flag
// - Count when run and gate off or pin high
// - Setting run bit keeps count intact
// - Mode 1 is full 16-bit count
// - Mode 2 reloads low byte from high
// - Channel one mode 3 holds count
// - Channel zero mode 3 low byte independent
// - Channel zero high byte uses channel one controls
// - Channel one still counts outside mode 3
// - Mode field decodes four modes
// - Mode register nibbles per channel
// - Pin activity sets external irq flag
// - Trigger type picks edge or level
// - Timer ticks every twelve oscillator periods
// - Counter input falling edge, sampled every twelve
// - Overflow flag cleared on interrupt service
// - Type one falling edge, zero low level
package tmr_pkg;
  // Register index; the byte address is four times the index
  localparam logic [7:0]  IDX_CTRL     = 8'h88;
  localparam logic [7:0]  IDX_MODE     = 8'h89;
  localparam logic [7:0]  IDX_CH0_LOW  = 8'h8a;
  localparam logic [7:0]  IDX_CH1_LOW  = 8'h8b;
  localparam logic [7:0]  IDX_CH0_HIGH = 8'h8c;
  localparam logic [7:0]  IDX_CH1_HIGH = 8'h8d;
  localparam logic [11:0] OFF_CTRL     = {2'b00, IDX_CTRL, 2'b00};
  localparam logic [11:0] OFF_MODE     = {2'b00, IDX_MODE, 2'b00};
  localparam logic [11:0] OFF_CH0_LOW  = {2'b00, IDX_CH0_LOW, 2'b00};
  localparam logic [11:0] OFF_CH1_LOW  = {2'b00, IDX_CH1_LOW, 2'b00};
  localparam logic [11:0] OFF_CH0_HIGH = {2'b00, IDX_CH0_HIGH, 2'b00};
  localparam logic [11:0] OFF_CH1_HIGH = {2'b00, IDX_CH1_HIGH, 2'b00};
  localparam logic [11:0] OFF_IRQ_STAT = 12'h240;
  localparam logic [11:0] OFF_IRQ_EN   = 12'h244;
  localparam logic [11:0] OFF_IRQ_CLR  = 12'h248;
  localparam logic [11:0] OFF_SERVICE  = 12'h24c;
  localparam int CTRL_OVF1 = 7;
  localparam int CTRL_RUN1 = 6;
  localparam int CTRL_OVF0 = 5;
  localparam int CTRL_RUN0 = 4;
  localparam int CTRL_EXT1 = 3;
  localparam int CTRL_TYP1 = 2;
  localparam int CTRL_EXT0 = 1;
  localparam int CTRL_TYP0 = 0;
  localparam int MODE_GATE = 3;
  localparam int MODE_CT   = 2;
  localparam int MODE_HI   = 1;
  localparam int MODE_LO   = 0;
  localparam int CH1_SHIFT = 4;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam int MODE13_LOW_BITS = 5;
  localparam int OSC_DIV = 12;
  typedef enum logic [1:0] {
    MODE_13BIT  = 2'b00,
    MODE_16BIT  = 2'b01,
    MODE_RELOAD = 2'b10,
    MODE_SPLIT  = 2'b11
  } chan_mode_e;
endpackage : tmr_pkg

/* src/tick_div.sv */
// Divider giving one-cycle tick enable pulse
`timescale 1ns/1ps
module tick_div #(
  parameter int DIV = 12
) (
  input  wire logic pclk,
  input  wire logic presetn,
  output logic      tick
);
  logic [7:0] cnt_q;
  wire        wrap = (cnt_q == 8'(DIV - 1));

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cnt_q <= 8'h00;
    else
      cnt_q <= wrap ? 8'h00 : cnt_q + 8'h01;
  end

  assign tick = wrap;
endmodule : tick_div

/* verif/dual_timer_checker.sv */
// Checker of bus, readback and interrupt behaviour for the dual timer
`timescale 1ns/1ps
module dual_timer_checker (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        ext_irq0_pin,
  input wire logic        ext_irq1_pin,
  input wire logic        chan0_count_pin,
  input wire logic        chan1_count_pin,
  input wire logic        irq
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic       acc;
  logic       wr_acc;
  logic       mapped;
  logic [7:0] mode_q;
  logic [3:0] en_q;
  logic       typ0_q;
  assign acc    = psel && penable;
  assign wr_acc = acc && pwrite;
  assign mapped = paddr inside {tmr_pkg::OFF_CTRL, tmr_pkg::OFF_MODE, tmr_pkg::OFF_CH0_LOW,
    tmr_pkg::OFF_CH1_LOW, tmr_pkg::OFF_CH0_HIGH, tmr_pkg::OFF_CH1_HIGH, tmr_pkg::OFF_IRQ_STAT,
    tmr_pkg::OFF_IRQ_EN, tmr_pkg::OFF_IRQ_CLR, tmr_pkg::OFF_SERVICE};
  // Shadows rebuilt from bus writes, since the bodies are not visible
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode_q <= 8'h00;
      en_q   <= 4'h0;
      typ0_q <= 1'b0;
    end
    else if (wr_acc)
    begin
      if (paddr == tmr_pkg::OFF_MODE)
        mode_q <= pwdata[7:0];
      if (paddr == tmr_pkg::OFF_IRQ_EN)
        en_q <= pwdata[3:0];
      if (paddr == tmr_pkg::OFF_CTRL)
        typ0_q <= pwdata[tmr_pkg::CTRL_TYP0];
    end
  end
  sequence fall0_s;
    $fell(ext_irq0_pin);
  endsequence
  sequence low0_s;
    !ext_irq0_pin [*2];
  endsequence
  zero_wait_a: assert property (acc |-> pready)
    else $error("access phase without ready");
  unmapped_err_a: assert property (acc && !mapped |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  mapped_ok_a: assert property (acc && mapped |-> !pslverr)
    else $error("mapped access refused");
  upper_zero_a: assert property (acc && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  mode_readback_a: assert property (
    acc && !pwrite && paddr == tmr_pkg::OFF_MODE |-> prdata[7:0] == mode_q)
    else $error("mode register readback differs");
  clear_reads_a: assert property (acc && !pwrite && paddr == tmr_pkg::OFF_IRQ_CLR |-> prdata == 0)
    else $error("clear register not reading zero");
  edge_irq_a: assert property ((typ0_q && en_q[0]) ##0 fall0_s |-> ##[1:3] irq)
    else $error("falling edge raised no interrupt");
  level_irq_a: assert property ((!typ0_q && en_q[0]) ##0 low0_s |-> ##[0:3] irq)
    else $error("low level raised no interrupt");
  irq_enable_a: assert property (irq |-> en_q != 4'h0)
    else $error("interrupt with all sources masked");
  irq_mask_a: assert property (
    wr_acc && paddr == tmr_pkg::OFF_IRQ_EN && pwdata[3:0] == 4'h0 |=> !irq)
    else $error("interrupt stays after masking");
endmodule : dual_timer_checker
bind dual_timer dual_timer_checker i_checker (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .ext_irq0_pin(ext_irq0_pin), .irq(irq),
  .ext_irq1_pin(ext_irq1_pin), .chan0_count_pin(chan0_count_pin),
  .chan1_count_pin(chan1_count_pin));

/* verif/testbench.sv */
// Self-checking bench for the dual timer over its register bus
`timescale 1ns/1ps
`define CHK(n, e, s) \
  begin \
    checked++; \
    if ((s) !== (e)) \
      begin \
        fail_count++; \
        $display("[FAIL] %s exp %h got %h", n, e, s); \
      end \
  end
module testbench;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, r;
  logic        pready, pslverr, irq, e, x0 = 1, x1 = 1, cp0 = 0, cp1 = 0;
  int          checked = 0, fail_count = 0, i;
  logic [7:0]  tm [3] = '{8'h00, 8'h01, 8'h02};
  logic [7:0]  th [3] = '{8'hff, 8'hff, 8'h5a};
  logic [7:0]  tl [3] = '{8'h1f, 8'hff, 8'hff};
  logic [7:0]  msk [3] = '{8'h1f, 8'hff, 8'hff};
  // Wrap result: zero in modes 0 and 1, reload value in mode 2
  logic [7:0]  ex [3] = '{8'h00, 8'h00, 8'h5a};
  dual_timer i_dual_timer (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_irq0_pin(x0), .ext_irq1_pin(x1), .chan0_count_pin(cp0),
    .chan1_count_pin(cp1), .irq(irq));
  always #4 pclk = ~pclk;
  task automatic conclude();
    $display("checked=%0d fail_count=%0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : conclude
  // Reply taken at the edge that sees pready, before that edge's updates land
  task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++)
    begin
      @(posedge pclk);
      if (pready === 1'b1)
        break;
    end
    if (pready !== 1'b1)
    begin
      fail_count++;
      conclude();
    end
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    xfer(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [11:0] a);
    xfer(1'b0, a, 8'h00);
  endtask : rd
  task automatic poll(input int b);
    r = 0;
    for (i = 0; i < 40 && r[b] !== 1'b1; i++)
      rd(tmr_pkg::OFF_CTRL);
  endtask : poll
  initial
  begin
    repeat (50000) @(posedge pclk);
    fail_count++;
    conclude();
  end
  initial
  begin
    repeat (6) @(posedge pclk);
    presetn <= 1;
    rd(tmr_pkg::OFF_MODE); `CHK("mode reset", 8'h00, r[7:0])
    rd(tmr_pkg::OFF_CTRL); `CHK("ctrl reset", 8'h00, r[7:0])
    wr(tmr_pkg::OFF_MODE, 8'ha5); rd(tmr_pkg::OFF_MODE); `CHK("mode rw", 8'ha5, r[7:0])
    xfer(1'b0, 12'h300, 8'h00); `CHK("unmapped", 33'h100000000, {e, r})
    for (int k = 0; k < 3; k++)
    begin
      wr(tmr_pkg::OFF_MODE, tm[k]); wr(tmr_pkg::OFF_CH0_HIGH, th[k]);
      wr(tmr_pkg::OFF_CH0_LOW, tl[k]);
      wr(tmr_pkg::OFF_SERVICE, 8'h04); rd(tmr_pkg::OFF_CTRL); `CHK("flag cleared", 1'b0, r[5])
      wr(tmr_pkg::OFF_CTRL, 8'h10); poll(5); wr(tmr_pkg::OFF_CTRL, 8'h00);
      `CHK("overflow flag", 1'b1, r[5])
      rd(tmr_pkg::OFF_CH0_LOW); `CHK("low after wrap", ex[k], r[7:0] & msk[k])
      rd(tmr_pkg::OFF_CH0_HIGH); `CHK("high after wrap", ex[k], r[7:0])
    end
    wr(tmr_pkg::OFF_IRQ_EN, 8'h04); rd(tmr_pkg::OFF_IRQ_STAT); `CHK("ovf status", 1'b1, r[2])
    `CHK("irq on", 1'b1, irq)
    wr(tmr_pkg::OFF_IRQ_EN, 8'h00); rd(tmr_pkg::OFF_IRQ_STAT); `CHK("irq masked", 1'b0, irq)
    wr(tmr_pkg::OFF_IRQ_CLR, 8'h04); rd(tmr_pkg::OFF_IRQ_STAT); `CHK("stat clr", 1'b0, r[2])
    wr(tmr_pkg::OFF_MODE, 8'h09); wr(tmr_pkg::OFF_CH0_LOW, 8'h77); x0 <= 0;
    wr(tmr_pkg::OFF_CTRL, 8'h10); repeat (60) @(posedge pclk); wr(tmr_pkg::OFF_CTRL, 8'h00);
    rd(tmr_pkg::OFF_CH0_LOW); `CHK("gate closed", 8'h77, r[7:0])
    x0 <= 1; wr(tmr_pkg::OFF_CH0_LOW, 8'h00);
    wr(tmr_pkg::OFF_CTRL, 8'h10); repeat (60) @(posedge pclk); wr(tmr_pkg::OFF_CTRL, 8'h00);
    // 63 running edges hold five or six ticks
    rd(tmr_pkg::OFF_CH0_LOW); `CHK("gate open", 1'b1, r[7:0] inside {[8'h05:8'h06]})
    wr(tmr_pkg::OFF_MODE, 8'h05); wr(tmr_pkg::OFF_CH0_LOW, 8'h00); wr(tmr_pkg::OFF_CTRL, 8'h10);
    repeat (3)
    begin
      cp0 <= 1; repeat (30) @(posedge pclk);
      cp0 <= 0; repeat (30) @(posedge pclk);
    end
    wr(tmr_pkg::OFF_CTRL, 8'h00); rd(tmr_pkg::OFF_CH0_LOW);
    `CHK("pin count", 8'h03, r[7:0])
    wr(tmr_pkg::OFF_MODE, 8'h03); wr(tmr_pkg::OFF_CH0_HIGH, 8'hff); wr(tmr_pkg::OFF_CTRL, 8'h40);
    poll(7); `CHK("split high ovf", 1'b1, r[7])
    wr(tmr_pkg::OFF_MODE, 8'h30); wr(tmr_pkg::OFF_CH1_LOW, 8'h10);
    repeat (50) @(posedge pclk); rd(tmr_pkg::OFF_CH1_LOW); `CHK("chan1 hold", 8'h10, r[7:0])
    // 52 running edges hold four or five ticks
    wr(tmr_pkg::OFF_MODE, 8'h13); repeat (50) @(posedge pclk);
    rd(tmr_pkg::OFF_CH1_LOW); `CHK("chan1 runs", 1'b1, r[7:0] inside {[8'h14:8'h15]})
    wr(tmr_pkg::OFF_CTRL, 8'h01); wr(tmr_pkg::OFF_IRQ_CLR, 8'h0f); wr(tmr_pkg::OFF_IRQ_EN, 8'h01);
    rd(tmr_pkg::OFF_IRQ_STAT); `CHK("no edge yet", 1'b0, r[0])
    x0 <= 0; repeat (3) @(posedge pclk); x0 <= 1; repeat (3) @(posedge pclk);
    rd(tmr_pkg::OFF_IRQ_STAT); `CHK("edge flag", 1'b1, r[0])
    x0 <= 0; wr(tmr_pkg::OFF_CTRL, 8'h00); wr(tmr_pkg::OFF_IRQ_CLR, 8'h01);
    rd(tmr_pkg::OFF_IRQ_STAT); `CHK("level flag", 1'b1, r[0])
    x0 <= 1;
    conclude();
  end
endmodule : testbench
